// ### rtl/pbcc_channel.sv
// Port bypass control channel: register, pin takeover, auto-clear and interrupt.
//
// Contract
// - A cleared force_bypass bit drives the force-bypass pin low (Bypass mode), a set bit high (Normal mode).
// - While enabled, a low filtered signal-detect level clears force_bypass in hardware well within 400 ns.
// - Bits 1 and 0 always read the synchronised and filtered pin levels, enabled or not.
// - Once enabled, writes to force_bypass act at any time while the signal-detect input stays high.
// - While enabled, bit 0 is read-only and shows the signal-detect pin.
// - signal_detected reads one when a high-speed signal is detected and zero when it is not.
// - Setting bit 7 turns the first pin into the force-bypass output and the second into the detect input.
// - While enabled, the channel overrides all other pin configuration except the bypass-select function.
// - While disabled, the other bits of the channel register have no effect on the two pins.
// - This channel sits at address 28h and acts on pin_group5_bit1 and pin_group5_bit0.
// - With signal_detect_irq_enable set, each detect transition sets status bit 0 and loads the source; the interrupt follows mask bit 0.
`timescale 1ns/10ps
module pbcc_channel (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          srst,
    // Register port
    input  wire logic [pbcc_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [pbcc_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [pbcc_pkg::DATA_W-1:0]   reg_rdata,
    // Force-bypass pin
    input  wire logic                          pin_group5_bit1_in,
    output logic                               pin_group5_bit1_out,
    output logic                               pin_group5_bit1_oe,
    // Signal-detect pin
    input  wire logic                          pin_group5_bit0_in,
    output logic                               pin_group5_bit0_out,
    output logic                               pin_group5_bit0_oe,
    // General pin configuration, index 0 is the force-bypass pin
    input  wire logic [pbcc_pkg::PIN_N-1:0]    gp_out_val,
    input  wire logic [pbcc_pkg::PIN_N-1:0]    gp_out_en,
    // Bypass-select function, index 0 is the force-bypass pin
    input  wire logic [pbcc_pkg::PIN_N-1:0]    bypass_sel_act,
    input  wire logic [pbcc_pkg::PIN_N-1:0]    bypass_sel_val,
    // Interrupt
    output logic                               irq,
    output logic                               interrupt_out_n,
    output logic      [pbcc_pkg::ADDR_W-1:0]   bit_change_irq_source
);

    typedef struct packed {
        logic                          en;
        logic                          signal_detect_irq_enable;
        logic                          fb;
        logic [pbcc_pkg::EV_W-1:0]     status;
        logic [pbcc_pkg::EV_W-1:0]     mask;
        logic [pbcc_pkg::ADDR_W-1:0]   src;
        logic [pbcc_pkg::DATA_W-1:0]   rdata;
        logic [pbcc_pkg::PIN_N-1:0]    pin_out;
        logic [pbcc_pkg::PIN_N-1:0]    pin_oe;
        logic                          irq;
    } pbcc_core_s;

    pbcc_core_s st;
    pbcc_core_s next_st;

    pbcc_filt_if fi ();

    logic                          wr_chan;
    logic                          wr_stat;
    logic                          wr_mask;
    logic                          sd_low;
    logic [pbcc_pkg::EV_W-1:0]     ev;
    logic [pbcc_pkg::EV_W-1:0]     w1c;
    logic [pbcc_pkg::DATA_W-1:0]   chan_rd;

    // Raw pins go straight to the synchroniser; nothing here looks at them.
    assign fi.pin_raw[pbcc_pkg::IDX_FB] = pin_group5_bit1_in;
    assign fi.pin_raw[pbcc_pkg::IDX_SD] = pin_group5_bit0_in;

    pbcc_sync_filt u_filt (
        .clk_sys (clk_sys),
        .srst    (srst),
        .fi      (fi)
    );

    assign wr_chan = reg_wr && (reg_addr == pbcc_pkg::CHAN_ADDR);
    assign wr_stat = reg_wr && (reg_addr == pbcc_pkg::IRQ_STAT);
    assign wr_mask = reg_wr && (reg_addr == pbcc_pkg::IRQ_MASK);

    assign sd_low = !fi.level[pbcc_pkg::IDX_SD];

    // The channel word shows both filtered pin levels, not the stored bypass
    // bit, so software can learn the strapped default before enabling.
    always_comb begin
        chan_rd                      = pbcc_pkg::RDATA_ZERO;
        chan_rd[pbcc_pkg::BIT_EN]    = st.en;
        chan_rd[pbcc_pkg::BIT_SIGNAL_DETECT_IRQ_ENABLE] = st.signal_detect_irq_enable;
        chan_rd[pbcc_pkg::BIT_FB]    = fi.level[pbcc_pkg::IDX_FB];
        chan_rd[pbcc_pkg::BIT_SD]    = fi.level[pbcc_pkg::IDX_SD];
    end

    always_comb begin
        w1c = pbcc_pkg::EV_ZERO;
        if (wr_stat) begin
            w1c = reg_wdata[pbcc_pkg::EV_W-1:0];
        end
    end

    always_comb begin
        next_st = st;
        ev      = pbcc_pkg::EV_ZERO;

        // Bit 0 is never stored, so it stays read-only whether or not the
        // channel is enabled.
        if (wr_chan) begin
            next_st.en    = reg_wdata[pbcc_pkg::BIT_EN];
            next_st.signal_detect_irq_enable = reg_wdata[pbcc_pkg::BIT_SIGNAL_DETECT_IRQ_ENABLE];
            next_st.fb    = reg_wdata[pbcc_pkg::BIT_FB];
        end

        // Hardware clear wins over a software write in the same cycle, so a
        // lost signal can never be masked by a late write of one.
        if (next_st.en && sd_low) begin
            next_st.fb = 1'b0;
            if (st.fb) begin
                ev[pbcc_pkg::EV_AUTOCLR] = 1'b1;
            end
        end

        if (st.signal_detect_irq_enable && fi.toggle[pbcc_pkg::IDX_SD]) begin
            ev[pbcc_pkg::EV_SD_EDGE] = 1'b1;
        end

        if (wr_mask) begin
            next_st.mask = reg_wdata[pbcc_pkg::EV_W-1:0];
        end

        // A new event in the cycle of its clear keeps the bit set.
        next_st.status = (st.status & ~w1c) | ev;

        if (ev[pbcc_pkg::EV_SD_EDGE]) begin
            next_st.src = pbcc_pkg::CHAN_ADDR;
        end else if (!next_st.status[pbcc_pkg::EV_SD_EDGE]) begin
            next_st.src = pbcc_pkg::SRC_NONE;
        end

        next_st.irq = |(next_st.status & next_st.mask);

        next_st.rdata = pbcc_pkg::RDATA_ZERO;
        if (reg_rd) begin
            unique case (reg_addr)
                pbcc_pkg::CHAN_ADDR: begin
                    next_st.rdata = chan_rd;
                end
                pbcc_pkg::IRQ_STAT: begin
                    next_st.rdata[pbcc_pkg::EV_W-1:0] = st.status;
                end
                pbcc_pkg::IRQ_MASK: begin
                    next_st.rdata[pbcc_pkg::EV_W-1:0] = st.mask;
                end
                pbcc_pkg::IRQ_SRC: begin
                    next_st.rdata = st.src;
                end
                default: begin
                    next_st.rdata = pbcc_pkg::RDATA_ZERO;
                end
            endcase
        end

        // Force-bypass pin: bypass select first, then the channel, then the
        // general configuration. The new bypass bit is used directly so the
        // auto-clear reaches the pin one edge after the filter drops.
        if (bypass_sel_act[pbcc_pkg::IDX_FB]) begin
            next_st.pin_out[pbcc_pkg::IDX_FB] = bypass_sel_val[pbcc_pkg::IDX_FB];
            next_st.pin_oe[pbcc_pkg::IDX_FB]  = 1'b1;
        end else if (next_st.en) begin
            next_st.pin_out[pbcc_pkg::IDX_FB] = next_st.fb;
            next_st.pin_oe[pbcc_pkg::IDX_FB]  = 1'b1;
        end else begin
            next_st.pin_out[pbcc_pkg::IDX_FB] = gp_out_val[pbcc_pkg::IDX_FB];
            next_st.pin_oe[pbcc_pkg::IDX_FB]  = gp_out_en[pbcc_pkg::IDX_FB];
        end

        // Signal-detect pin: released as an input while the channel owns it.
        if (bypass_sel_act[pbcc_pkg::IDX_SD]) begin
            next_st.pin_out[pbcc_pkg::IDX_SD] = bypass_sel_val[pbcc_pkg::IDX_SD];
            next_st.pin_oe[pbcc_pkg::IDX_SD]  = 1'b1;
        end else if (next_st.en) begin
            next_st.pin_out[pbcc_pkg::IDX_SD] = 1'b0;
            next_st.pin_oe[pbcc_pkg::IDX_SD]  = 1'b0;
        end else begin
            next_st.pin_out[pbcc_pkg::IDX_SD] = gp_out_val[pbcc_pkg::IDX_SD];
            next_st.pin_oe[pbcc_pkg::IDX_SD]  = gp_out_en[pbcc_pkg::IDX_SD];
        end
    end

    // Both pins come out of reset as undriven inputs, like every other pin.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st.en      <= 1'b0;
            st.signal_detect_irq_enable   <= 1'b0;
            st.fb      <= pbcc_pkg::FB_RST;
            st.status  <= pbcc_pkg::EV_ZERO;
            st.mask    <= pbcc_pkg::EV_ZERO;
            st.src     <= pbcc_pkg::SRC_NONE;
            st.rdata   <= pbcc_pkg::RDATA_ZERO;
            st.pin_out <= pbcc_pkg::PIN_ZERO;
            st.pin_oe  <= pbcc_pkg::PIN_ZERO;
            st.irq     <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata             = st.rdata;
    assign pin_group5_bit1_out   = st.pin_out[pbcc_pkg::IDX_FB];
    assign pin_group5_bit1_oe    = st.pin_oe[pbcc_pkg::IDX_FB];
    assign pin_group5_bit0_out   = st.pin_out[pbcc_pkg::IDX_SD];
    assign pin_group5_bit0_oe    = st.pin_oe[pbcc_pkg::IDX_SD];
    assign irq                   = st.irq;
    assign interrupt_out_n       = !st.irq;
    assign bit_change_irq_source = st.src;

endmodule

// ### pkg/pbcc_pkg.sv
// Constants shared by the port bypass control channel and its input filter.
package pbcc_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PIN_N  = 2;
    localparam int unsigned EV_W   = 2;
    localparam int unsigned CNT_W  = 4;

    localparam logic [ADDR_W-1:0] CHAN_ADDR   = 8'h28;
    localparam logic [ADDR_W-1:0] IRQ_STAT    = 8'h30;
    localparam logic [ADDR_W-1:0] IRQ_MASK    = 8'h31;
    localparam logic [ADDR_W-1:0] IRQ_SRC     = 8'h32;
    localparam logic [ADDR_W-1:0] SRC_NONE    = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_ZERO  = 8'h00;

    localparam int unsigned BIT_EN    = 7;
    localparam int unsigned BIT_SIGNAL_DETECT_IRQ_ENABLE = 6;
    localparam int unsigned BIT_FB    = 1;
    localparam int unsigned BIT_SD    = 0;

    localparam int unsigned IDX_FB = 0;
    localparam int unsigned IDX_SD = 1;

    localparam int unsigned EV_SD_EDGE = 0;
    localparam int unsigned EV_AUTOCLR = 1;

    localparam logic             FB_RST    = 1'b1;
    localparam logic             PIN_RST   = 1'b1;
    localparam logic [EV_W-1:0]  EV_ZERO   = 2'h0;
    localparam logic [PIN_N-1:0] PIN_ZERO  = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;

    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned LOSS_LAT_NS   = 400;
    localparam int unsigned LOSS_LAT_CYC  = LOSS_LAT_NS / CLK_PERIOD_NS;
    localparam int unsigned FILT_NS       = 32;
    localparam int unsigned FILT_CYC_I    = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] FILT_CYC = CNT_W'(FILT_CYC_I);

endpackage

// ### pkg/pbcc_filt_if.sv
// Carrier between the channel core and its pin synchroniser and filter.
`timescale 1ns/10ps
interface pbcc_filt_if;
    logic [pbcc_pkg::PIN_N-1:0] pin_raw;
    logic [pbcc_pkg::PIN_N-1:0] level;
    logic [pbcc_pkg::PIN_N-1:0] toggle;

    modport filt (
        input  pin_raw,
        output level,
        output toggle
    );

    modport core (
        output pin_raw,
        input  level,
        input  toggle
    );
endinterface

// ### rtl/pbcc_sync_filt.sv
// Two-flop synchroniser and stability filter for the channel's two pins.
`timescale 1ns/10ps
module pbcc_sync_filt (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // Core side
    pbcc_filt_if.filt fi
);

    typedef struct packed {
        logic [pbcc_pkg::PIN_N-1:0]                        meta;
        logic [pbcc_pkg::PIN_N-1:0]                        sync;
        logic [pbcc_pkg::PIN_N-1:0]                        level;
        logic [pbcc_pkg::PIN_N-1:0]                        toggle;
        logic [pbcc_pkg::PIN_N-1:0][pbcc_pkg::CNT_W-1:0]   cnt;
    } pbcc_filt_s;

    pbcc_filt_s st;
    pbcc_filt_s next_st;

    // A new level is taken only after it has stood for the whole filter window,
    // so a short glitch on the detect line never clears the bypass control.
    always_comb begin
        next_st      = st;
        next_st.meta = fi.pin_raw;
        next_st.sync = st.meta;
        for (int i = 0; i < pbcc_pkg::PIN_N; i++) begin
            next_st.toggle[i] = 1'b0;
            if (st.sync[i] == st.level[i]) begin
                next_st.cnt[i] = pbcc_pkg::CNT_ZERO;
            end else if (st.cnt[i] == pbcc_pkg::FILT_CYC - pbcc_pkg::CNT_ONE) begin
                next_st.cnt[i]    = pbcc_pkg::CNT_ZERO;
                next_st.level[i]  = st.sync[i];
                next_st.toggle[i] = 1'b1;
            end else begin
                next_st.cnt[i] = st.cnt[i] + pbcc_pkg::CNT_ONE;
            end
        end
    end

    // Pins power up pulled high, so the filter starts from a high level.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st.meta   <= {pbcc_pkg::PIN_N{pbcc_pkg::PIN_RST}};
            st.sync   <= {pbcc_pkg::PIN_N{pbcc_pkg::PIN_RST}};
            st.level  <= {pbcc_pkg::PIN_N{pbcc_pkg::PIN_RST}};
            st.toggle <= pbcc_pkg::PIN_ZERO;
            st.cnt    <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fi.level  = st.level;
    assign fi.toggle = st.toggle;

endmodule

// ### verif/pbcc_channel_sva.sv
// Assertion checker for the port bypass control channel.
`timescale 1ns/10ps
module pbcc_channel_sva (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins and pin configuration
    input wire logic       pin_group5_bit1_out,
    input wire logic       pin_group5_bit1_oe,
    input wire logic       pin_group5_bit0_in,
    input wire logic       pin_group5_bit0_oe,
    input wire logic [1:0] gp_out_en,
    input wire logic [1:0] bypass_sel_act,
    input wire logic [1:0] bypass_sel_val,
    // Interrupt
    input wire logic       irq,
    input wire logic       interrupt_out_n
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    // Only an enabled channel drives the pin with neither override active.
    sequence sd_lost;
        (!pin_group5_bit0_in && pin_group5_bit1_oe && !gp_out_en[0] && !bypass_sel_act[0]) [*8];
    endsequence
    sequence sel_held;
        bypass_sel_act[0] ##1 (bypass_sel_act[0] && $stable(bypass_sel_val));
    endsequence
    a_loss_clear: assert property (sd_lost ##1 sd_lost
        |-> ##[0:84] !pin_group5_bit1_out)
        else $error("force-bypass pin high after loss of signal");
    a_irq_polarity: assert property (interrupt_out_n == !irq)
        else $error("interrupt outputs disagree");
    a_mask_quiet: assert property (reg_wr && reg_addr == 8'h31
        && reg_wdata[1:0] == 2'h0 |=> !irq && interrupt_out_n)
        else $error("interrupt raised with every source masked");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_unmapped_read: assert property (reg_rd
        && !(reg_addr inside {8'h28, 8'h30, 8'h31, 8'h32}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property (reg_rd && reg_addr == 8'h28
        |=> reg_rdata[5:2] == 4'h0)
        else $error("reserved bits not zero");
    a_enable_pins: assert property (reg_wr && reg_addr == 8'h28 && reg_wdata[7]
        && bypass_sel_act == 2'h0 |=> pin_group5_bit1_oe && !pin_group5_bit0_oe)
        else $error("enable did not take the pins");
    a_disabled_pins: assert property (reg_wr && reg_addr == 8'h28 && !reg_wdata[7]
        && bypass_sel_act == 2'h0 |=> {pin_group5_bit1_oe, pin_group5_bit0_oe}
        == {$past(gp_out_en[0]), $past(gp_out_en[1])})
        else $error("disabled channel still owns the pins");
    a_select_wins: assert property (sel_held |-> pin_group5_bit1_oe
        && pin_group5_bit1_out == bypass_sel_val[0])
        else $error("bypass select did not override");
endmodule

bind pbcc_channel pbcc_channel_sva chk_i (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_group5_bit1_out(pin_group5_bit1_out), .pin_group5_bit1_oe(pin_group5_bit1_oe),
    .pin_group5_bit0_in(pin_group5_bit0_in), .pin_group5_bit0_oe(pin_group5_bit0_oe),
    .gp_out_en(gp_out_en), .bypass_sel_act(bypass_sel_act), .bypass_sel_val(bypass_sel_val),
    .irq(irq), .interrupt_out_n(interrupt_out_n)
);

// ### verif/pbcc_far_side.sv
// Model of the external bypass and signal-detect unit on the channel's pins.
`timescale 1ns/10ps
module pbcc_far_side (
    // Device pin drive
    input  wire logic fb_out,
    input  wire logic fb_oe,
    input  wire logic sd_out,
    input  wire logic sd_oe,
    // Commanded detect state
    input  wire logic sd_level,
    // Pin levels and loop mode
    output logic      fb_pin,
    output logic      sd_pin,
    output logic      bypass_mode
);
    // A released force-bypass pin floats to the weak pull-up; a released detect pin follows sd_level.
    assign fb_pin      = fb_oe ? fb_out : 1'b1;
    assign sd_pin      = sd_oe ? sd_out : sd_level;
    assign bypass_mode = !fb_pin;
endmodule

// ### verif/pbcc_channel_bench.sv
// Self-checking bench for the port bypass control channel.
`timescale 1ns/10ps
module pbcc_channel_bench;
    logic       clk_sys = 1'b0;
    logic       srst, reg_wr, reg_rd, sd_level;
    logic [7:0] reg_addr, reg_wdata, rd_val;
    logic [1:0] gp_out_val, gp_out_en, bypass_sel_act, bypass_sel_val;
    wire        fb_pin, sd_pin, bypass_mode, fb_out, fb_oe, sd_out, sd_oe, irq, irq_n;
    wire  [7:0] reg_rdata, src;
    int         n_errors = 0;
    int         samples_checked = 0;

    always #2 clk_sys = ~clk_sys;

    pbcc_channel uut (
        .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_group5_bit1_in(fb_pin), .pin_group5_bit1_out(fb_out), .pin_group5_bit1_oe(fb_oe),
        .pin_group5_bit0_in(sd_pin), .pin_group5_bit0_out(sd_out), .pin_group5_bit0_oe(sd_oe),
        .gp_out_val(gp_out_val), .gp_out_en(gp_out_en), .bypass_sel_act(bypass_sel_act),
        .bypass_sel_val(bypass_sel_val), .irq(irq), .interrupt_out_n(irq_n),
        .bit_change_irq_source(src));
    pbcc_far_side far_i (
        .fb_out(fb_out), .fb_oe(fb_oe), .sd_out(sd_out), .sd_oe(sd_oe), .sd_level(sd_level),
        .fb_pin(fb_pin), .sd_pin(sd_pin), .bypass_mode(bypass_mode));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask

    task automatic t_reset();
        chk({5'h00, fb_oe, sd_oe, sd_out}, 8'h02);
        rd(8'h28);
        chk(rd_val, 8'h02);
        @(posedge clk_sys);
        gp_out_en <= 2'h0;
        idle(14);
        rd(8'h28);
        chk(rd_val, 8'h03);
        rd(8'h05);
        chk(rd_val, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_enable();
        // Default level written with the enable bit so enabling does not glitch the loop.
        wr(8'h28, 8'h82);
        chk({5'h00, bypass_mode, fb_oe, sd_oe}, 8'h02);
        wr(8'h28, 8'h80);
        chk({7'h00, bypass_mode}, 8'h01);
        idle(14);
        rd(8'h28);
        chk(rd_val, 8'h81);
        wr(8'h28, 8'h82);
        idle(14);
        rd(8'h28);
        chk(rd_val, 8'h83);
        $display("test enable done");
    endtask
    task automatic t_loss();
        int i;
        wr(8'h28, 8'hc2);
        wr(8'h31, 8'h00);
        @(posedge clk_sys);
        sd_level <= 1'b0;
        for (i = 0; i < 100 && fb_out; i++) begin
            idle(1);
        end
        chk({7'h00, fb_out}, 8'h00);
        if (fb_out) begin
            give_verdict();
        end
        wr(8'h28, 8'hc2);
        chk({7'h00, fb_out}, 8'h00);
        idle(4);
        chk({6'h00, irq, irq_n}, 8'h01);
        rd(8'h30);
        chk(rd_val, 8'h03);
        chk(src, 8'h28);
        rd(8'h32);
        chk(rd_val, 8'h28);
        wr(8'h31, 8'h03);
        idle(1);
        chk({6'h00, irq, irq_n}, 8'h02);
        rd(8'h31);
        chk(rd_val, 8'h03);
        rd(8'h28);
        chk(rd_val, 8'hc0);
        wr(8'h30, 8'h03);
        idle(1);
        chk({src[6:0], irq}, 8'h00);
        @(posedge clk_sys);
        sd_level <= 1'b1;
        idle(16);
        chk({6'h00, irq, irq_n}, 8'h02);
        chk(src, 8'h28);
        wr(8'h30, 8'h03);
        wr(8'h31, 8'h00);
        $display("test loss done");
    endtask
    task automatic t_override();
        wr(8'h28, 8'h42);
        chk({6'h00, fb_oe, sd_oe}, 8'h00);
        @(posedge clk_sys);
        gp_out_val <= 2'h1;
        gp_out_en  <= 2'h1;
        idle(2);
        chk({6'h00, fb_oe, fb_out}, 8'h03);
        @(posedge clk_sys);
        bypass_sel_act <= 2'h1;
        idle(2);
        chk({6'h00, fb_oe, fb_out}, 8'h02);
        wr(8'h28, 8'h82);
        idle(1);
        chk({6'h00, fb_oe, fb_out}, 8'h02);
        @(posedge clk_sys);
        bypass_sel_act <= 2'h0;
        gp_out_val     <= 2'h0;
        idle(2);
        chk({5'h00, bypass_mode, fb_oe, fb_out}, 8'h03);
        $display("test override done");
    endtask

    initial begin
        srst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        sd_level = 1'b1;
        gp_out_val = 2'h0;
        gp_out_en = 2'h2;
        bypass_sel_act = 2'h0;
        bypass_sel_val = 2'h0;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        idle(14);
        t_reset();
        t_enable();
        t_loss();
        t_override();
        give_verdict();
    end
    initial begin
        #100000;
        n_errors++;
        give_verdict();
    end
endmodule
